// [logic/fpe_map.svh]
// register offsets, field positions, memory map and reset values of the flash sequencer
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH

`define FPE_OFF_CTRL      18'h0_0000
`define FPE_OFF_PROT      18'h0_0004
`define FPE_OFF_STAT      18'h0_0008
`define FPE_ARRAY_SEL_BIT 18

`define FPE_CTRL_RESET    4'h0
`define FPE_PROT_RESET    8'h00
`define FPE_PROT_NONE     8'hFF

`define FPE_USER_LO       16'hC000
`define FPE_USER_HI       16'hEFFF
`define FPE_VEC_LO        16'hFFD0
`define FPE_VEC_INDEX     16'h3000
`define FPE_ARRAY_LAST    14'h302F
`define FPE_PAGE_LAST     14'h007F
`define FPE_PAGE_MASK     14'h3F80
`define FPE_ERASED        8'hFF

`endif

// [logic/fpe_pkg.sv]
// types shared by the flash sequencer
package fpe_pkg;

    typedef struct packed {
        logic hv;
        logic mass;
        logic erase;
        logic program_select;
    } fpe_ctrl_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        valid;
    } fpe_target_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ERASE
    } fpe_state_t;

endpackage

// [logic/fpe_top.sv]
// flash program/erase sequencer with block protection behind an apb slave
// Summary of operation
// - erased bits read one; programming only clears bits to zero.
// - array covers 12288 user bytes C000-EFFF plus 48 vector bytes FFD0-FFFF.
// - page erase clears one 128-byte page aligned on 00 or 80.
// - high voltage sets only with program or erase selected and target written.
// - high voltage bit drives both charge pump and array high voltage.
// - whole-array select picks mass erase, otherwise single page erase.
// - program and erase never both one; a write setting both is refused.
// - page erase never touches the vector page; only mass erase does.
// - programming works on 64-byte rows aligned on 00, 40, 80, C0.
// - with program selected, array writes latch; first write fixes the row.
// - protected target blocks setting high voltage for erase and program.
// - protected range runs from protect start up to FFFF inclusive.
// - start address is 11, protect bits 7..1, then seven zeros.
// - protect value FF disables protection; otherwise bit 0 ignored.
// - protect value zero protects the whole array.
// - block protect value is an 8-bit apb read/write register.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "fpe_map.svh"

module fpe_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [19:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             charge_pump_on,
    output logic             array_high_voltage
);

    fpe_pkg::fpe_ctrl_t   flash_control_reg;
    fpe_pkg::fpe_ctrl_t   ctrl_next;
    fpe_pkg::fpe_ctrl_t   req_ctrl;
    fpe_pkg::fpe_target_t target_reg;
    fpe_pkg::fpe_target_t target_next;
    fpe_pkg::fpe_state_t  state_reg;
    logic [7:0]           block_protect_reg;
    logic [13:0]          ptr_reg;
    logic [13:0]          end_reg;
    logic [31:0]          prdata_reg;
    logic                 pready_reg;
    logic                 pslverr_reg;
    logic                 pump_reg;
    logic                 hv_out_reg;
    logic [7:0]           mem [0:`FPE_ARRAY_LAST];

    // array index: user bytes first, vector bytes stacked right after them
    function automatic logic [13:0] fpe_index(input logic [15:0] a);
        logic [15:0] d;
        d = (a >= `FPE_VEC_LO) ? (a - `FPE_VEC_LO + `FPE_VEC_INDEX) : (a - `FPE_USER_LO);
        return d[13:0];
    endfunction

    // apb phase and address decode
    wire        setup     = psel & ~penable;
    wire        access    = psel & penable & pready_reg;
    wire        is_array  = paddr[`FPE_ARRAY_SEL_BIT];
    wire [15:0] arr_addr  = paddr[17:2];
    wire        in_user   = (arr_addr >= `FPE_USER_LO) && (arr_addr <= `FPE_USER_HI);
    wire        in_vec    = (arr_addr >= `FPE_VEC_LO);
    wire        arr_hit   = is_array & (in_user | in_vec);
    wire [13:0] arr_idx   = fpe_index(arr_addr);
    wire        hit_ctrl  = ~is_array & (paddr[17:0] == `FPE_OFF_CTRL);
    wire        hit_prot  = ~is_array & (paddr[17:0] == `FPE_OFF_PROT);
    wire        hit_stat  = ~is_array & (paddr[17:0] == `FPE_OFF_STAT);
    wire        unmapped  = ~(arr_hit | hit_ctrl | hit_prot | hit_stat) | (paddr[1:0] != 2'b00);
    wire        wr_ctrl   = access & pwrite & hit_ctrl;
    wire        wr_prot   = access & pwrite & hit_prot;
    wire        wr_array  = access & pwrite & arr_hit;
    wire [7:0]  mem_rd    = arr_hit ? mem[arr_idx] : `FPE_ERASED;

    // protection window; the vector page always sits inside it when active
    wire [15:0] prot_start    = {2'b11, block_protect_reg[7:1], 7'h00};
    wire        prot_active   = (block_protect_reg != `FPE_PROT_NONE);
    wire        tgt_protected = prot_active & (target_reg.addr >= prot_start);

    // control write: interlock, then high voltage gating
    assign req_ctrl       = fpe_pkg::fpe_ctrl_t'(pwdata[3:0]);
    wire   both_sel       = req_ctrl.erase & req_ctrl.program_select;
    wire   sel_kept       = (req_ctrl.program_select & flash_control_reg.program_select) | (req_ctrl.erase & flash_control_reg.erase);
    wire   hv_allowed     = sel_kept & target_reg.valid & ~tgt_protected;
    wire   ctrl_taken     = wr_ctrl & ~both_sel;
    wire   hv_rise        = ctrl_taken & ctrl_next.hv & ~flash_control_reg.hv;

    always_comb begin
        ctrl_next = flash_control_reg;
        if (ctrl_taken) begin
            ctrl_next    = req_ctrl;
            // an already-on pump stays on while the select bit is cleared
            ctrl_next.hv = req_ctrl.hv & (flash_control_reg.hv | hv_allowed);
        end
    end

    // target latch: only the first array write after select counts
    wire   sel_any   = flash_control_reg.program_select | flash_control_reg.erase;
    wire   tgt_latch = wr_array & sel_any & ~flash_control_reg.hv & ~target_reg.valid;

    always_comb begin
        target_next = target_reg;
        if (tgt_latch) begin
            target_next.addr  = arr_addr;
            target_next.valid = 1'b1;
        end
        if (~(ctrl_next.program_select | ctrl_next.erase)) begin
            target_next.valid = 1'b0;
        end
    end

    // erase launch: mass covers everything, page covers 128 aligned bytes
    wire [13:0] tgt_idx      = fpe_index(target_reg.addr);
    wire        tgt_in_vec   = (target_reg.addr >= `FPE_VEC_LO);
    wire        erase_go     = hv_rise & ctrl_next.erase & (ctrl_next.mass | ~tgt_in_vec);
    wire [13:0] page_first   = tgt_idx & `FPE_PAGE_MASK;
    wire [13:0] first_next   = ctrl_next.mass ? 14'h0000 : page_first;
    wire [13:0] last_next    = ctrl_next.mass ? `FPE_ARRAY_LAST : (page_first | `FPE_PAGE_LAST);
    wire        erasing      = (state_reg == fpe_pkg::ST_ERASE);

    // programming only inside the latched 64-byte row, with the pump up
    wire        row_match = (arr_addr[15:6] == target_reg.addr[15:6]);
    wire        prog_wr   = wr_array & flash_control_reg.program_select & flash_control_reg.hv
                            & target_reg.valid & row_match & ~erasing;

    // control, protect and target registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_control_reg <= fpe_pkg::fpe_ctrl_t'(`FPE_CTRL_RESET);
            block_protect_reg <= `FPE_PROT_RESET;
            target_reg        <= '0;
        end else begin
            flash_control_reg <= ctrl_next;
            target_reg        <= target_next;
            if (wr_prot) begin
                block_protect_reg <= pwdata[7:0];
            end
        end
    end

    // erase walker: one byte per clock, just inside the erase time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= fpe_pkg::ST_IDLE;
            ptr_reg   <= 14'h0000;
            end_reg   <= 14'h0000;
        end else begin
            case (state_reg)
                fpe_pkg::ST_IDLE: begin
                    if (erase_go) begin
                        state_reg <= fpe_pkg::ST_ERASE;
                        ptr_reg   <= first_next;
                        end_reg   <= last_next;
                    end
                end
                fpe_pkg::ST_ERASE: begin
                    ptr_reg <= ptr_reg + 14'h0001;
                    if (ptr_reg == end_reg) begin
                        state_reg <= fpe_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= fpe_pkg::ST_IDLE;
            endcase
        end
    end

    // array storage has no reset; contents survive a bus reset like real cells
    always_ff @(posedge pclk) begin
        if (erasing) begin
            mem[ptr_reg] <= `FPE_ERASED;
        end else if (prog_wr) begin
            mem[arr_idx] <= mem_rd & pwdata[7:0];
        end
    end

    // read mux and error decision are prepared in the setup cycle
    wire [31:0] stat_word = {target_reg.addr, 13'h0000, tgt_protected, erasing, target_reg.valid};
    wire [31:0] rd_word   = hit_ctrl ? {28'h000_0000, flash_control_reg} :
                            hit_prot ? {24'h00_0000, block_protect_reg} :
                            hit_stat ? stat_word :
                            arr_hit  ? {24'h00_0000, mem_rd} : 32'h0000_0000;
    wire        err_now   = unmapped | (pwrite & hit_ctrl & both_sel);

    // bus answer: pready high only in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & err_now;
            if (setup & ~pwrite) begin
                prdata_reg <= err_now ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // pump and array high voltage follow the enable bit together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_reg   <= 1'b0;
            hv_out_reg <= 1'b0;
        end else begin
            pump_reg   <= ctrl_next.hv;
            hv_out_reg <= ctrl_next.hv;
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign charge_pump_on     = pump_reg;
    assign array_high_voltage = hv_out_reg;

    // helper: length of each erase run, for the checks below
    logic [13:0] erase_cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_cnt_reg <= 14'h0000;
        end else if (erase_go) begin
            erase_cnt_reg <= 14'h0000;
        end else if (erasing) begin
            erase_cnt_reg <= erase_cnt_reg + 14'h0001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_hv_request;
        wr_ctrl && req_ctrl.hv && !flash_control_reg.hv && !both_sel;
    endsequence

    sequence s_page_start;
        erase_go && !ctrl_next.mass;
    endsequence

    a_sel_never_both: assert property (!(flash_control_reg.program_select && flash_control_reg.erase))
        else $error("program and erase select both set");
    a_both_write_refused: assert property (wr_ctrl && both_sel |=> $stable(flash_control_reg) && pslverr_reg == 1'b0)
        else $error("write setting both selects was not refused");
    a_hv_needs_target: assert property (s_hv_request ##1 flash_control_reg.hv |-> $past(target_reg.valid))
        else $error("high voltage set without a written target");
    a_hv_protect_block: assert property (s_hv_request and tgt_protected |=> !flash_control_reg.hv)
        else $error("high voltage set on a protected target");
    a_pump_tracks_hv: assert property (charge_pump_on == flash_control_reg.hv && array_high_voltage == charge_pump_on)
        else $error("pump or high voltage output disagrees with enable bit");
    a_page_erase_len: assert property (s_page_start |=> erasing [*8] ##120 erasing ##1 !erasing)
        else $error("page erase did not last exactly 128 cycles");
    a_page_align: assert property (s_page_start |=> ptr_reg[6:0] == 7'h00)
        else $error("page erase not aligned to 128 bytes");
    a_vec_page_kept: assert property (hv_rise && ctrl_next.erase && !ctrl_next.mass && tgt_in_vec |=> !erasing)
        else $error("page erase started on the vector page");
    a_mass_range: assert property (erase_go && ctrl_next.mass |=> ptr_reg == 14'h0000 && end_reg == `FPE_ARRAY_LAST)
        else $error("mass erase does not cover the whole array");
    a_erase_fills_ones: assert property (erasing |=> mem[$past(ptr_reg)] == `FPE_ERASED)
        else $error("erased byte does not read all ones");
    a_prog_clears_only: assert property (prog_wr |=> mem[$past(arr_idx)] == ($past(mem_rd) & $past(pwdata[7:0])))
        else $error("programming set a bit to one");
    a_row_fixed: assert property (target_reg.valid && $past(target_reg.valid) |-> $stable(target_reg.addr))
        else $error("target row changed while latched");
    a_prot_none_open: assert property (block_protect_reg == `FPE_PROT_NONE |-> !tgt_protected)
        else $error("protection active with protect value all ones");
    a_prot_zero_all: assert property (block_protect_reg == 8'h00 && target_reg.valid |-> tgt_protected)
        else $error("zero protect value left target open");
    a_prot_reg_rw: assert property (wr_prot |=> block_protect_reg == $past(pwdata[7:0]))
        else $error("protect register did not take written value");
    a_pready_pulse: assert property (setup |=> pready_reg ##1 !pready_reg)
        else $error("pready not a single access cycle pulse");

    // erase length, select gating, row limits and protect start examples
    a_mass_erase_len: assert property (
        erasing && end_reg == `FPE_ARRAY_LAST && ptr_reg == end_reg |-> erase_cnt_reg == `FPE_ARRAY_LAST)
        else $error("mass erase did not visit every byte");
    a_page_span: assert property (s_page_start |=> end_reg - ptr_reg == `FPE_PAGE_LAST)
        else $error("page erase span is not one page");
    a_page_in_user: assert property (s_page_start |=> end_reg < `FPE_VEC_INDEX)
        else $error("page erase reached the vector page");
    a_hv_rise_sel: assert property (flash_control_reg.hv && !$past(flash_control_reg.hv) |-> $past(sel_any))
        else $error("high voltage rose with no select kept");
    a_hv_no_target: assert property (s_hv_request and !target_reg.valid |=> !flash_control_reg.hv)
        else $error("high voltage set before a target write");
    a_hv_drop_pump: assert property (
        wr_ctrl && !both_sel && !req_ctrl.hv |=> !charge_pump_on && !array_high_voltage)
        else $error("pump stayed on after high voltage cleared");
    a_prog_row_only: assert property (
        wr_array && flash_control_reg.program_select && !row_match && !erasing |=> mem[$past(arr_idx)] == $past(mem_rd))
        else $error("byte outside the latched row was programmed");
    a_target_clear: assert property (!sel_any |-> !target_reg.valid)
        else $error("target kept with no select set");
    a_prot_start_bit: assert property (
        block_protect_reg == 8'h02 && target_reg.valid && target_reg.addr == 16'hC07F |-> !tgt_protected)
        else $error("byte below the protect start was protected");
    a_prot_lsb_ignored: assert property (
        block_protect_reg == 8'h03 && target_reg.valid && target_reg.addr == 16'hC080 |-> tgt_protected)
        else $error("protect bit 0 changed the start address");
    a_err_unmapped: assert property (setup && unmapped |=> pslverr_reg && pready_reg)
        else $error("unmapped access not answered with an error");

endmodule

// [verif/fpe_sw_model.sv]
// apb software model that runs erase and program routines on the flash sequencer
module fpe_sw_model #(
    parameter int T_NVS  = 3,
    parameter int T_PAGE = 130,
    parameter int T_MASS = 12340,
    parameter int T_PROG = 2,
    parameter int T_NVH  = 2
) (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [19:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] last_rd;
    logic        last_err;

    // bus idle at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 20'h0_0000;
        pwdata  = 32'h0000_0000;
    end

    // one apb transfer; a clock edge passes first so a release never meets a new setup
    task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no answer time assumed; only the bench watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        last_rd  = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d; // stale data must not look valid
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [19:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // array window address of a flash byte
    function automatic logic [19:0] aa(input logic [15:0] fa);
        return {2'b01, fa, 2'b00};
    endfunction

    // waits scaled down from the real times, each rounded up to whole cycles
    task automatic erase(input logic [15:0] fa, input logic mass);
        wr(20'h0_0000, {28'h000_0000, 1'b0, mass, 2'b10});
        wr(aa(fa), 32'h0000_0000);
        wt(T_NVS);
        wr(20'h0_0000, {28'h000_0000, 1'b1, mass, 2'b10});
        wt(mass ? T_MASS : T_PAGE);
        wr(20'h0_0000, 32'h0000_0008);
        wt(T_NVH);
        wr(20'h0_0000, 32'h0000_0000);
        wt(T_NVH);
    endtask

    // each entry is address then byte; the first write only names the row
    task automatic prog(input logic [15:0] row, input logic [23:0] q[$]);
        wr(20'h0_0000, 32'h0000_0001);
        wr(aa(row), 32'h0000_00FF);
        wt(T_NVS);
        wr(20'h0_0000, 32'h0000_0009);
        wt(T_NVS);
        foreach (q[i]) begin
            wr(aa(q[i][23:8]), {24'h00_0000, q[i][7:0]});
            wt(T_PROG);
        end
        wr(20'h0_0000, 32'h0000_0008);
        wt(T_NVH);
        wr(20'h0_0000, 32'h0000_0000);
        wt(T_NVH);
    endtask
endmodule

// [verif/fpe_top_tb_top.sv]
// self-checking bench for the flash sequencer
module fpe_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk;
    logic        presetn;
    wire logic        psel;
    wire logic        penable;
    wire logic        pwrite;
    wire logic [19:0] paddr;
    wire logic [31:0] pwdata;
    wire logic [31:0] prdata;
    wire logic        pready;
    wire logic        pslverr;
    wire logic        charge_pump_on;
    wire logic        array_high_voltage;
    int          n_fail;
    int          total_checks;
    logic        prot_exp;
    localparam logic [19:0] A_CTRL = 20'h0_0000;
    localparam logic [19:0] A_PROT = 20'h0_0004;
    localparam logic [19:0] A_STAT = 20'h0_0008;
    localparam logic [23:0] PT [7] = '{24'h00_C000, 24'h01_EFFF, 24'h02_C07F, 24'h03_C080,
                                       24'hFE_EFFF, 24'hFE_FFD0, 24'hFF_FFFF};

    fpe_top u_fpe_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .charge_pump_on(charge_pump_on), .array_high_voltage(array_high_voltage));

    fpe_sw_model u_fpe_sw_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 25 mhz bus clock
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic rdchk(input logic [19:0] a, input logic [31:0] exp, input string msg);
        u_fpe_sw_model.rd(a);
        chk(u_fpe_sw_model.last_rd, exp, msg);
    endtask

    // outputs are looked at mid-cycle, after the write edge has landed
    task automatic outchk(input logic [1:0] exp);
        @(negedge pclk);
        chk({30'h0000_0000, charge_pump_on, array_high_voltage}, {30'h0000_0000, exp}, "pump outputs");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog sized well above two mass erases plus the register traffic
    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        stop_test();
    end

    initial begin
        presetn = 1'b0;
        n_fail = 0;
        total_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(A_PROT, 32'h0000_0000, "protect reset");
        outchk(2'b00);
        u_fpe_sw_model.wr(A_PROT, 32'h0000_00FF);
        rdchk(A_PROT, 32'h0000_00FF, "protect readback");
        u_fpe_sw_model.wr(A_CTRL, 32'h0000_0003);
        chk({31'h0000_0000, u_fpe_sw_model.last_err}, 32'h0000_0001, "both selects refused");
        rdchk(A_CTRL, 32'h0000_0000, "control after refusal");
        u_fpe_sw_model.wr(u_fpe_sw_model.aa(16'hF000), 32'h0000_0000);
        chk({31'h0000_0000, u_fpe_sw_model.last_err}, 32'h0000_0001, "hole in array refused");
        rdchk(u_fpe_sw_model.aa(16'hF000), 32'h0000_0000, "hole read");
        chk({31'h0000_0000, u_fpe_sw_model.last_err}, 32'h0000_0001, "hole read refused");
        u_fpe_sw_model.wr(A_CTRL, 32'h0000_0008);
        rdchk(A_CTRL, 32'h0000_0000, "hv without select");
        u_fpe_sw_model.wr(A_CTRL, 32'h0000_0002);
        u_fpe_sw_model.wr(A_CTRL, 32'h0000_000A);
        rdchk(A_CTRL, 32'h0000_0002, "hv without target");
        u_fpe_sw_model.wr(A_CTRL, 32'h0000_0000);
        $display("register tests done");
        u_fpe_sw_model.erase(16'hC000, 1'b1);
        rdchk(u_fpe_sw_model.aa(16'hC000), 32'h0000_00FF, "erased low");
        rdchk(u_fpe_sw_model.aa(16'hEFFF), 32'h0000_00FF, "erased high");
        u_fpe_sw_model.prog(16'hC040, '{24'hC0_40A5, 24'hC0_7F3C, 24'hC0_8000});
        u_fpe_sw_model.prog(16'hC080, '{24'hC0_8012});
        u_fpe_sw_model.prog(16'hFFD0, '{24'hFF_D055});
        rdchk(u_fpe_sw_model.aa(16'hC040), 32'h0000_00A5, "row first byte");
        rdchk(u_fpe_sw_model.aa(16'hC07F), 32'h0000_003C, "row last byte");
        rdchk(u_fpe_sw_model.aa(16'hC080), 32'h0000_0012, "next row");
        rdchk(u_fpe_sw_model.aa(16'hFFD0), 32'h0000_0055, "vector byte");
        u_fpe_sw_model.erase(16'hC040, 1'b0);
        rdchk(u_fpe_sw_model.aa(16'hC040), 32'h0000_00FF, "page erased");
        rdchk(u_fpe_sw_model.aa(16'hC080), 32'h0000_0012, "next page kept");
        u_fpe_sw_model.erase(16'hFFD0, 1'b0);
        rdchk(u_fpe_sw_model.aa(16'hFFD0), 32'h0000_0055, "vector page kept");
        u_fpe_sw_model.erase(16'hC000, 1'b1);
        rdchk(u_fpe_sw_model.aa(16'hFFD0), 32'h0000_00FF, "vector mass erased");
        $display("erase and program tests done");
        foreach (PT[i]) begin
            u_fpe_sw_model.wr(A_PROT, {24'h00_0000, PT[i][23:16]});
            u_fpe_sw_model.wr(A_CTRL, 32'h0000_0001);
            u_fpe_sw_model.wr(u_fpe_sw_model.aa(PT[i][15:0]), 32'h0000_00FF);
            u_fpe_sw_model.wr(A_CTRL, 32'h0000_0009);
            prot_exp = PT[i][23:16] != 8'hFF && PT[i][15:0] >= {2'b11, PT[i][23:17], 7'h00};
            outchk({2{~prot_exp}});
            rdchk(A_STAT, {PT[i][15:0], 13'h0000, prot_exp, 1'b0, 1'b1}, "status target");
            rdchk(A_CTRL, {28'h000_0000, ~prot_exp, 3'b001}, "protect gate");
            u_fpe_sw_model.wr(A_CTRL, 32'h0000_0000);
            outchk(2'b00);
        end
        $display("protection tests done");
        // reset in mid-run with the pump up: outputs drop at once, registers return to reset
        u_fpe_sw_model.wr(A_CTRL, 32'h0000_0001);
        u_fpe_sw_model.wr(u_fpe_sw_model.aa(16'hC000), 32'h0000_00FF);
        u_fpe_sw_model.wr(A_CTRL, 32'h0000_0009);
        outchk(2'b11);
        @(posedge pclk);
        presetn <= 1'b0;
        outchk(2'b00);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(A_CTRL, 32'h0000_0000, "control after reset");
        rdchk(A_PROT, 32'h0000_0000, "protect after reset");
        outchk(2'b00);
        $display("reset tests done");
        stop_test();
    end
endmodule
